// ---- rtl/inc_ctrl.v ----
/*
 Interrupt acknowledge, nesting and context switch controller.
 Assumes request pulses and CPU sequencer strobes come from logic on
 i_sys_clk; the sequencer performs stack pushes, pops and transfers
 according to the acknowledge kind reported here.
*/
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/100ps
`include "inc_defines.vh"
module inc_ctrl (
  // Clock and reset
  input  wire        i_sys_clk,
  input  wire        i_rst,
  // Register port
  input  wire [7:0]  i_addr,
  input  wire [15:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [15:0] o_rdata,
  // Peripheral request pulses and NMI in-service flags
  input  wire [18:0] i_irq,
  input  wire [1:0]  i_nmi_isr,
  // CPU sequencer
  input  wire        i_boundary,
  input  wire [15:0] i_pc,
  input  wire [15:0] i_psw,
  input  wire        i_ei,
  input  wire        i_di,
  input  wire        i_vectored_return_instr,
  input  wire        i_vectored_return_instr_ie,
  input  wire        i_bank_switch_return_instr,
  input  wire [15:0] i_bank_switch_return_instr_addr,
  output reg         o_ack,
  output reg  [4:0]  o_ack_src,
  output reg  [2:0]  o_ack_kind,
  output reg  [15:0] o_vec_addr,
  output reg  [15:0] o_new_pc,
  output reg  [15:0] o_new_psw,
  output reg         o_restore,
  output reg  [2:0]  o_bank,
  output reg         o_ie,
  output reg  [7:0]  o_in_service_level_reg
);

  localparam NS = `INC_NSRC;

  reg  [4:0]  ctl_r   [0:NS-1];
  reg  [7:0]  cnt_r   [0:NS-1];
  reg  [15:0] bvec_r  [0:`INC_NBANK-1];
  reg  [15:0] bpc_r   [0:`INC_NBANK-1];
  reg  [15:0] bpsw_r  [0:`INC_NBANK-1];
  reg  [2:0]  bprev_r [0:`INC_NBANK-1];
  reg  [18:0] req_r;
  reg  [3:0]  isr_r;
  reg  [2:0]  mode_r;
  reg         ie_r;
  reg  [2:0]  bank_r;

  reg  [18:0] elig;
  reg  [18:0] act;
  reg  [18:0] clr_nxt;
  reg  [18:0] set_nxt;
  reg         best_ok;
  reg  [4:0]  best_src;
  reg  [1:0]  best_lv;
  reg  [2:0]  lim;
  reg  [15:0] rd_nxt;
  integer     i;
  integer     j;

  wire        ret_any = i_vectored_return_instr | i_bank_switch_return_instr;
  wire        take    = i_boundary & best_ok & ~ret_any;
  wire [4:0]  bctl    = ctl_r[best_src];
  wire [15:0] bvaddr  = vec_of(best_src);
  wire [2:0]  sel_bk  = bvaddr[3:1];
  wire [7:0]  bcnt    = cnt_r[best_src];
  wire        ms_last = (bcnt == 8'h01) || (bcnt == 8'h00);

  function [15:0] vec_of;
    input [4:0] s;
    begin
      vec_of = `INC_VEC_BASE + {10'h000, s, 1'b0};
    end
  endfunction

  // Lowest set bit as one-hot; lowest index is the best level
  function [3:0] first_set;
    input [3:0] v;
    begin
      first_set = v & (~v + 4'h1);
    end
  endfunction

  // Address decode shared by read and write paths; is_ctl also feeds the request path
  function is_ctl;
    input [7:0] a;
    begin
      is_ctl = (a < (`INC_A_CTL + NS));
    end
  endfunction

  function is_cnt;
    input [7:0] a;
    begin
      is_cnt = (a >= `INC_A_CNT) && (a < (`INC_A_CNT + NS));
    end
  endfunction

  function is_bvec;
    input [7:0] a;
    begin
      is_bvec = (a[7:3] == (`INC_A_BVEC >> 3));
    end
  endfunction

  // Admission limit from the in-service levels
  always @* begin
    lim = 3'h4;
    if (isr_r[0])
      lim = 3'h0;
    else if (isr_r[1])
      lim = 3'h1;
    else if (isr_r[2])
      lim = 3'h2;
    else if (isr_r[3])
      lim = mode_r[`INC_F_NEST] ? 3'h3 : 3'h4;
  end

  // shared hardware idles the partner source
  always @* begin
    act = {NS{1'b1}};
    act[15] = ~mode_r[`INC_F_SHR14];
    act[18] = ~mode_r[`INC_F_SHR17];
  end

  always @* begin
    best_ok  = 1'b0;
    best_src = 5'h00;
    best_lv  = 2'h3;
    for (i = 0; i < NS; i = i + 1) begin
      elig[i] = req_r[i] & ~ctl_r[i][`INC_F_MASK] & act[i] &
                (ctl_r[i][`INC_F_MS] |
                 (ie_r & (i_nmi_isr == 2'h0) &
                  ({1'b0, ctl_r[i][`INC_F_LVL_HI:`INC_F_LVL_LO]} < lim)));
      if (elig[i] && (!best_ok || ctl_r[i][1:0] < best_lv)) begin
        best_ok  = 1'b1;
        best_src = i[4:0];
        best_lv  = ctl_r[i][1:0];
      end
    end
  end

  // Request flags: hardware set beats any clear in the same cycle
  always @* begin
    clr_nxt = 19'h00000;
    set_nxt = i_irq;
    // Write one sets, write zero clears
    if (i_wr && is_ctl(i_addr)) begin
      clr_nxt[i_addr[4:0]] = ~i_wdata[`INC_F_REQ];
      set_nxt[i_addr[4:0]] = i_irq[i_addr[4:0]] | i_wdata[`INC_F_REQ];
    end
    // last transfer leaves request pending for the vector
    if (take && !(bctl[`INC_F_MS] && ms_last))
      clr_nxt[best_src] = 1'b1;
  end

  always @* begin
    rd_nxt = 16'h0000;
    if (is_ctl(i_addr))
      rd_nxt = {10'h000, req_r[i_addr[4:0]], ctl_r[i_addr[4:0]]};
    else if (is_cnt(i_addr))
      rd_nxt = {8'h00, cnt_r[i_addr[4:0]]};
    else if (i_addr == `INC_A_MODE)
      rd_nxt = {13'h0000, mode_r};
    else if (i_addr == `INC_A_STAT)
      rd_nxt = {i_nmi_isr, 2'h0, isr_r, 4'h0, bank_r, ie_r};
    else if (is_bvec(i_addr))
      rd_nxt = bvec_r[i_addr[2:0]];
  end

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      for (j = 0; j < NS; j = j + 1) begin
        ctl_r[j] <= `INC_CTL_RST;
        cnt_r[j] <= `INC_CNT_RST;
      end
      for (j = 0; j < `INC_NBANK; j = j + 1) begin
        bvec_r[j]  <= 16'h0000;
        bpc_r[j]   <= 16'h0000;
        bpsw_r[j]  <= 16'h0000;
        bprev_r[j] <= 3'h0;
      end
      req_r      <= 19'h00000;
      isr_r      <= 4'h0;
      mode_r     <= `INC_MODE_RST;
      ie_r       <= 1'b0;
      bank_r     <= 3'h0;
      o_rdata    <= 16'h0000;
      o_ack      <= 1'b0;
      o_ack_src  <= 5'h00;
      o_ack_kind <= 3'h0;
      o_vec_addr <= 16'h0000;
      o_new_pc   <= 16'h0000;
      o_new_psw  <= 16'h0000;
      o_restore  <= 1'b0;
      o_bank     <= 3'h0;
      o_ie       <= 1'b0;
      o_in_service_level_reg     <= 8'h00;
    end else begin
      o_rdata   <= i_rd ? rd_nxt : 16'h0000;
      o_ack     <= take;
      // Vectored return wins when both arrive
      o_restore <= i_bank_switch_return_instr & ~i_vectored_return_instr;
      req_r     <= (req_r & ~clr_nxt) | set_nxt;
      // Unmapped writes are ignored
      if (i_wr) begin
        if (is_ctl(i_addr))
          ctl_r[i_addr[4:0]] <= i_wdata[4:0];
        else if (is_cnt(i_addr))
          cnt_r[i_addr[4:0]] <= i_wdata[7:0];
        else if (i_addr == `INC_A_MODE)
          mode_r <= i_wdata[2:0];
        else if (is_bvec(i_addr))
          bvec_r[i_addr[2:0]] <= i_wdata;
      end
      if (i_ei)
        ie_r <= 1'b1;
      else if (i_di)
        ie_r <= 1'b0;
      if (i_vectored_return_instr) begin
        isr_r <= isr_r & ~first_set(isr_r);
        ie_r  <= i_vectored_return_instr_ie;
      end else if (i_bank_switch_return_instr) begin
        // restore bank context, record next start
        isr_r           <= isr_r & ~first_set(isr_r);
        o_new_pc        <= bpc_r[bank_r];
        o_new_psw       <= bpsw_r[bank_r];
        ie_r            <= bpsw_r[bank_r][`INC_PSW_IE];
        bvec_r[bank_r]  <= i_bank_switch_return_instr_addr;
        bank_r          <= bprev_r[bank_r];
        o_bank          <= bprev_r[bank_r];
      end else if (take) begin
        o_ack_src  <= best_src;
        o_vec_addr <= bvaddr;
        if (bctl[`INC_F_MS]) begin
          o_ack_kind      <= `INC_K_MS;
          cnt_r[best_src] <= ms_last ? 8'h00 : bcnt - 8'h01;
          if (ms_last)
            ctl_r[best_src] <= bctl & ~(5'h01 << `INC_F_MS);
        end else begin
          ie_r  <= 1'b0;
          isr_r <= isr_r | (4'h1 << best_lv);
          if (bctl[`INC_F_CTX]) begin
            o_ack_kind      <= `INC_K_CTX;
            bprev_r[sel_bk] <= bank_r;
            bpc_r[sel_bk]   <= i_pc;
            bpsw_r[sel_bk]  <= i_psw;
            o_new_pc        <= bvec_r[sel_bk];
            bank_r          <= sel_bk;
            o_bank          <= sel_bk;
          end else begin
            // stack save, load from vector table
            o_ack_kind <= `INC_K_VEC;
          end
        end
      end
      // Mirrors lag internal state by one cycle
      o_ie   <= ie_r;
      o_in_service_level_reg <= {i_nmi_isr, 2'h0, isr_r};
    end
  end

endmodule // inc_ctrl

// ---- rtl/inc_defines.vh ----
/*
 Constants of the interrupt acknowledge and nesting block:
 register offsets, field positions, reset values and sizes.
 Assumes inclusion by the block's single design file only.
*/
`ifndef INC_DEFINES_VH
`define INC_DEFINES_VH
// Sizes
`define INC_NSRC        19
`define INC_NBANK       8
// Register offsets (byte addresses, 8-bit address bus)
`define INC_A_CTL       8'h00
`define INC_A_CNT       8'h20
`define INC_A_MODE      8'h40
`define INC_A_STAT      8'h41
`define INC_A_BVEC      8'h48
// Per-source control field positions
`define INC_F_LVL_LO    0
`define INC_F_LVL_HI    1
`define INC_F_MASK      2
`define INC_F_CTX       3
`define INC_F_MS        4
`define INC_F_REQ       5
// Mode register fields
`define INC_F_NEST      0
`define INC_F_SHR14     1
`define INC_F_SHR17     2
// Status register fields
`define INC_F_IE        0
`define INC_F_ISR_LO    8
// Processor status word bit that holds the global enable
`define INC_PSW_IE      5
// Reset values
`define INC_CTL_RST     5'h07
`define INC_CNT_RST     8'h00
`define INC_MODE_RST    3'h0
// Vector table base; entries are two bytes apart
`define INC_VEC_BASE    16'h0008
// Acknowledge kinds, one-hot
`define INC_K_VEC       3'h1
`define INC_K_CTX       3'h2
`define INC_K_MS        3'h4
`endif

// ---- testbench/inc_ctrl_sva.sv ----
/* Port checker for inc_ctrl.
   Assumes a single clock domain and a synchronous high reset. */
`timescale 1ns/100ps
module inc_ctrl_sva (
  // Clock and inputs
  input wire        i_sys_clk,
  input wire        i_rst,
  input wire        i_boundary,
  input wire        i_vectored_return_instr,
  input wire        i_bank_switch_return_instr,
  input wire [1:0]  i_nmi_isr,
  // Outputs
  input wire        o_ack,
  input wire [4:0]  o_ack_src,
  input wire [2:0]  o_ack_kind,
  input wire [15:0] o_vec_addr,
  input wire        o_restore,
  input wire [2:0]  o_bank,
  input wire        o_ie,
  input wire [7:0]  o_in_service_level_reg
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  wire br = o_ack && o_ack_kind != 3'h4;
  AST_ACK_CAUSE: assert property (o_ack |-> $past(i_boundary) && !$past(i_vectored_return_instr) && !$past(i_bank_switch_return_instr))
    else $error("ack without free boundary");
  AST_VEC_ADDR: assert property (o_ack |-> o_vec_addr == 16'h0008 + {10'h000, o_ack_src, 1'b0})
    else $error("wrong vector address");
  AST_CTX_BANK: assert property (o_ack && o_ack_kind == 3'h2 |-> o_bank == o_vec_addr[3:1])
    else $error("wrong bank");
  AST_IE_CLR: assert property (br |=> !o_ie)
    else $error("enable left set");
  AST_NMI_BLOCK: assert property (br |-> $past(i_nmi_isr) == 2'h0)
    else $error("branch during nmi");
  AST_ISR_SET: assert property (o_ack && o_ack_kind == 3'h1 |=> o_in_service_level_reg[3:0] != 4'h0)
    else $error("no level in service");
  AST_ONE_KIND: assert property (o_ack |-> $onehot(o_ack_kind))
    else $error("kind not one-hot");
  AST_RESTORE: assert property (o_restore == ($past(i_bank_switch_return_instr) && !$past(i_vectored_return_instr)))
    else $error("restore pulse wrong");
  cover property (o_ack && o_ack_kind == 3'h2);
  cover property (o_ack && o_ack_kind == 3'h4);
  cover property (o_restore);
endmodule // inc_ctrl_sva
bind inc_ctrl inc_ctrl_sva u_sva (.*);

// ---- testbench/inc_cpu_model.sv ----
/* CPU sequencer model: boundary pulses, PC/PROCESSOR_STATUS_WORD, matching returns.
   Assumes one-cycle step and return requests from the bench. */
`timescale 1ns/100ps
module inc_cpu_model (
  // Clock and reset
  input  wire        i_sys_clk,
  input  wire        i_rst,
  // Bench requests
  input  wire        i_step,
  input  wire        i_ret,
  // Controller side
  input  wire        i_ack,
  input  wire [2:0]  i_ack_kind,
  input  wire        i_ie,
  output reg         o_boundary,
  output reg  [15:0] o_pc,
  output wire [15:0] o_psw,
  output reg         o_vectored_return_instr,
  output reg         o_bank_switch_return_instr
);
  // Top of stack in bit 0: one flag per open handler
  reg [7:0] ctx_stk_r;
  assign o_psw = {10'h000, i_ie, 5'h00};
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_boundary <= 1'b0;
      o_pc <= 16'h0100;
      ctx_stk_r <= 8'h00;
      o_vectored_return_instr <= 1'b0;
      o_bank_switch_return_instr <= 1'b0;
    end else begin
      o_boundary <= i_step;
      o_pc <= o_pc + {15'h0000, i_step};
      o_vectored_return_instr <= i_ret & ~ctx_stk_r[0];
      o_bank_switch_return_instr <= i_ret & ctx_stk_r[0];
      if (i_ack && i_ack_kind != 3'h4)
        ctx_stk_r <= {ctx_stk_r[6:0], i_ack_kind == 3'h2};
      else if (i_ret)
        ctx_stk_r <= {1'b0, ctx_stk_r[7:1]};
    end
  end
endmodule // inc_cpu_model

// ---- testbench/test_interrupt_nesting_ctx_switch.sv ----
/* Self-checking bench for inc_ctrl with the sequencer model.
   Assumes the checker is bound by its own file. */
`timescale 1ns/100ps
module test_interrupt_nesting_ctx_switch;
  reg         i_sys_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  reg         i_ei = 1'b0, i_di = 1'b0, step = 1'b0, ret = 1'b0;
  reg  [7:0]  i_addr = 8'h00;
  reg  [15:0] i_wdata = 16'h0000;
  reg  [18:0] i_irq = 19'h0;
  reg  [1:0]  i_nmi_isr = 2'h0;
  wire        bnd, vectored_return_instr, bank_switch_return_instr, o_ack, o_restore, o_ie;
  wire [15:0] pc, processor_status_word, o_rdata, o_vec_addr, npc, npsw;
  wire [4:0]  o_ack_src;
  wire [2:0]  o_ack_kind, o_bank;
  wire [7:0]  o_in_service_level_reg;
  integer     err_total = 0, compares = 0, i;
  reg  [4:0]  got;
  reg  [2:0]  kind;
  reg  [31:0] rows [0:3];
  always #5 i_sys_clk = ~i_sys_clk;
  inc_cpu_model cpu (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_step(step), .i_ret(ret), .i_ack(o_ack),
    .i_ack_kind(o_ack_kind), .i_ie(o_ie), .o_boundary(bnd), .o_pc(pc), .o_psw(processor_status_word), .o_vectored_return_instr(vectored_return_instr), .o_bank_switch_return_instr(bank_switch_return_instr));
  inc_ctrl dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_irq(i_irq), .i_nmi_isr(i_nmi_isr), .i_boundary(bnd), .i_pc(pc), .i_psw(processor_status_word), .i_ei(i_ei),
    .i_di(i_di), .i_vectored_return_instr(vectored_return_instr), .i_vectored_return_instr_ie(1'b1), .i_bank_switch_return_instr(bank_switch_return_instr), .i_bank_switch_return_instr_addr(16'h0200), .o_ack(o_ack),
    .o_ack_src(o_ack_src), .o_ack_kind(o_ack_kind), .o_vec_addr(o_vec_addr), .o_new_pc(npc), .o_new_psw(npsw),
    .o_restore(o_restore), .o_bank(o_bank), .o_ie(o_ie), .o_in_service_level_reg(o_in_service_level_reg));
  task chk(input [63:0] nm, input [15:0] seen, input [15:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("BAD %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task results;
    begin
      if (err_total == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    begin
      @(posedge i_sys_clk) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
      @(posedge i_sys_clk) i_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [15:0] e);
    begin
      @(posedge i_sys_clk) {i_rd, i_addr} <= {1'b1, a};
      @(posedge i_sys_clk) i_rd <= 1'b0;
      #1 chk("rdata", o_rdata, e);
    end
  endtask
  task ei;
    begin
      @(posedge i_sys_clk) i_ei <= 1'b1;
      @(posedge i_sys_clk) i_ei <= 1'b0;
    end
  endtask
  task back;
    begin
      @(posedge i_sys_clk) ret <= 1'b1;
      @(posedge i_sys_clk) ret <= 1'b0;
      repeat (3) @(posedge i_sys_clk);
    end
  endtask
  // Source 31 stands for no acknowledge in the window
  task go(input [4:0] e);
    begin
      @(posedge i_sys_clk) step <= 1'b1;
      @(posedge i_sys_clk) step <= 1'b0;
      got = 5'h1f;
      repeat (4) begin
        @(posedge i_sys_clk) #1;
        if (o_ack === 1'b1) {got, kind} = {o_ack_src, o_ack_kind};
      end
      chk("ack_src", {11'h0, got}, {11'h0, e});
    end
  endtask
  initial begin
    #200000 err_total = err_total + 1;
    results;
  end
  initial begin
    // Source, control, count, kind
    rows[0] = {8'd3, 8'h20, 8'h00, 8'h01};
    rows[1] = {8'd18, 8'h23, 8'h00, 8'h01};
    rows[2] = {8'd5, 8'h29, 8'h00, 8'h02};
    rows[3] = {8'd9, 8'h33, 8'h05, 8'h04};
    repeat (20) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    rd(8'h00, 16'h0007);
    rd(8'h41, 16'h0000);
    for (i = 0; i < 4; i = i + 1) begin
      ei;
      wr(8'h20 + rows[i][31:24], {8'h00, rows[i][15:8]});
      wr(rows[i][31:24], {8'h00, rows[i][23:16]});
      go(rows[i][28:24]);
      chk("kind", {13'h0, kind}, {13'h0, rows[i][2:0]});
      // Bank is vector address bits 3:1, vectors start at 8
      if (rows[i][2:0] == 3'h2) chk("bank", {13'h0, o_bank}, {13'h0, rows[i][26:24] + 3'h4});
      if (rows[i][2:0] != 3'h4) back;
      chk("in_service_level_reg", {8'h0, o_in_service_level_reg}, 16'h0000);
    end
    ei;
    wr(8'h02, 16'h0021);
    go(5'd2);
    ei;
    wr(8'h01, 16'h0022);
    go(5'h1f);
    wr(8'h04, 16'h0020);
    go(5'd4);
    back;
    back;
    go(5'd1);
    ei;
    wr(8'h07, 16'h0022);
    wr(8'h06, 16'h0021);
    go(5'd6);
    back;
    ei;
    go(5'h1f);
    back;
    wr(8'h40, 16'h0001);
    // Level 3 in service for the nest select cases
    wr(8'h07, 16'h0023);
    ei;
    go(5'd7);
    ei;
    wr(8'h0b, 16'h0023);
    go(5'h1f);
    wr(8'h40, 16'h0000);
    go(5'd11);
    back;
    back;
    i_nmi_isr <= 2'h1;
    wr(8'h0c, 16'h0020);
    go(5'h1f);
    wr(8'h2d, 16'h0001);
    wr(8'h0d, 16'h0030);
    go(5'd13);
    i_nmi_isr <= 2'h0;
    go(5'd12);
    back;
    go(5'd13);
    chk("kind", {13'h0, kind}, 16'h0001);
    back;
    wr(8'h10, 16'h0000);
    @(posedge i_sys_clk) i_irq <= 19'h10000;
    @(posedge i_sys_clk) i_irq <= 19'h0;
    go(5'd16);
    back;
    ei;
    wr(8'h05, 16'h0029);
    go(5'd5);
    chk("new_pc", npc, 16'h0200);
    back;
    chk("new_psw", npsw, 16'h0020);
    results;
  end
endmodule // test_interrupt_nesting_ctx_switch
